// *** hdl/wdt_top.sv ***
// Watchdog timer unit with APB register access, timed-access protection and reset generation
`timescale 1ns/1ps
`default_nettype none
module wdt_top #(
    parameter int TAP0        = wdt_pkg::TAP_CODE0,
    parameter int TAP1        = wdt_pkg::TAP_CODE1,
    parameter int TAP2        = wdt_pkg::TAP_CODE2,
    parameter int TAP3        = wdt_pkg::TAP_CODE3,
    parameter int GRACE_COUNT = wdt_pkg::POST_TIMEOUT_CLOCKS
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset,
    // Power events (same clock domain)
    input  wire logic        power_on_reset,
    input  wire logic        power_down_reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Outputs
    output logic             watchdog_irq,
    output logic             event_irq,
    output logic             system_reset_out
);
    localparam int RC_W = $clog2(wdt_pkg::RESET_CLOCKS + 1);
    localparam int GC_W = $clog2(GRACE_COUNT + 1);

    logic [7:0]            clock_control_reg;
    logic                  serial_double;
    logic                  power_on_flag;
    logic                  timeout_flag;
    logic                  watchdog_reset_cause_flag;
    logic                  watchdog_reset_enable;
    logic                  watchdog_restart;
    logic                  global_interrupt_enable;
    logic                  watchdog_interrupt_enable;
    logic [wdt_pkg::EVT_WIDTH-1:0] evt_status;
    logic [wdt_pkg::EVT_WIDTH-1:0] evt_enable;
    logic [wdt_pkg::EVT_WIDTH-1:0] evt_set;

    wdt_pkg::wdt_state_t   state;
    logic [GC_W-1:0]       grace_cnt;
    logic [RC_W-1:0]       reset_cnt;
    logic [1:0]            phase;

    logic                  access;
    logic                  wr;
    logic                  mapped;
    logic                  wr_watchdog_control_reg;
    logic                  unlock_wr;
    logic                  window_open;
    logic                  timeout_pulse;
    logic                  wdog_fires;
    logic                  internal_clear;
    logic                  reset_last;

    // Zero-wait APB slave: every access completes in its access phase
    assign access = psel && penable;
    assign wr     = access && pwrite;
    // Unmapped offsets answer with an error and change nothing
    always_comb begin
        unique case (paddr)
            wdt_pkg::OFS_CLOCK_CONTROL, wdt_pkg::OFS_WATCHDOG_CONTROL, wdt_pkg::OFS_UNLOCK,
            wdt_pkg::OFS_INT_ENABLE, wdt_pkg::OFS_EVT_STATUS, wdt_pkg::OFS_EVT_CLEAR,
            wdt_pkg::OFS_EVT_ENABLE: mapped = 1'b1;
            default:                 mapped = 1'b0;
        endcase
    end
    assign wr_watchdog_control_reg  = wr && paddr == wdt_pkg::OFS_WATCHDOG_CONTROL;
    assign unlock_wr = wr && paddr == wdt_pkg::OFS_UNLOCK;

    // Watchdog resets everything but the sequencer, the APB response, the power-related bits and the event status, enable and event_irq logic
    assign internal_clear = reset || (state == wdt_pkg::WDT_RESETTING);

    // A watchdog reset also closes an open unlock window
    wdt_unlock #(
        .WINDOW_CLOCKS(wdt_pkg::UNLOCK_CLOCKS)
    ) u_unlock (
        .clk_sys    (clk_sys),
        .reset      (internal_clear),
        .unlock_wr  (unlock_wr),
        .unlock_data(pwdata[7:0]),
        .window_open(window_open)
    );

    // Divider is cleared by a watchdog reset too, so each run starts from zero
    wdt_divider #(
        .WIDTH(TAP3),
        .TAP0 (TAP0),
        .TAP1 (TAP1),
        .TAP2 (TAP2),
        .TAP3 (TAP3)
    ) u_divider (
        .clk_sys        (clk_sys),
        .reset          (internal_clear),
        .restart        (watchdog_restart),
        .interval_select({clock_control_reg[wdt_pkg::SEL_HI_BIT], clock_control_reg[wdt_pkg::SEL_LO_BIT]}),
        .timeout_pulse  (timeout_pulse)
    );

    // Clock control register: unprotected
    always_ff @(posedge clk_sys) begin
        if (internal_clear) begin
            clock_control_reg <= wdt_pkg::CLOCK_CONTROL_RESET;
        end else if (wr && paddr == wdt_pkg::OFS_CLOCK_CONTROL) begin
            clock_control_reg <= pwdata[7:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (internal_clear) begin
            global_interrupt_enable   <= wdt_pkg::INT_ENABLE_RESET[wdt_pkg::GLOBAL_IE_BIT];
            watchdog_interrupt_enable <= wdt_pkg::INT_ENABLE_RESET[wdt_pkg::WDOG_IE_BIT];
        end else if (wr && paddr == wdt_pkg::OFS_INT_ENABLE) begin
            global_interrupt_enable   <= pwdata[wdt_pkg::GLOBAL_IE_BIT];
            watchdog_interrupt_enable <= pwdata[wdt_pkg::WDOG_IE_BIT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (internal_clear) begin
            serial_double <= 1'b0;
        end else if (wr_watchdog_control_reg) begin
            serial_double <= pwdata[wdt_pkg::SERIAL_DOUBLE_BIT];
        end
    end

    // Power-on flag: set by power-up, cleared only by protected write
    always_ff @(posedge clk_sys) begin
        if (power_on_reset) begin
            power_on_flag <= 1'b1;
        end else if (wr_watchdog_control_reg && window_open) begin
            power_on_flag <= pwdata[wdt_pkg::POWER_ON_FLAG_BIT];
        end
    end

    // Reset enable survives external and watchdog resets
    always_ff @(posedge clk_sys) begin
        if (power_on_reset) begin
            watchdog_reset_enable <= 1'b0;
        end else if (wr_watchdog_control_reg && window_open) begin
            watchdog_reset_enable <= pwdata[wdt_pkg::RESET_ENABLE_BIT];
        end
    end

    // Restart bit self-clears one clock after it is written
    always_ff @(posedge clk_sys) begin
        if (internal_clear) begin
            watchdog_restart <= 1'b0;
        end else if (wr_watchdog_control_reg && window_open && pwdata[wdt_pkg::RESTART_BIT]) begin
            watchdog_restart <= 1'b1;
        end else begin
            watchdog_restart <= 1'b0;
        end
    end

    // Time-out flag: hardware set wins over a software clear
    always_ff @(posedge clk_sys) begin
        if (internal_clear) begin
            timeout_flag <= 1'b0;
        end else if (timeout_pulse) begin
            timeout_flag <= 1'b1;
        end else if (wr_watchdog_control_reg && window_open) begin
            timeout_flag <= pwdata[wdt_pkg::TIMEOUT_FLAG_BIT];
        end
    end

    // Cause flag: untouched by external reset, cleared by power events
    always_ff @(posedge clk_sys) begin
        if (power_on_reset || power_down_reset) begin
            watchdog_reset_cause_flag <= 1'b0;
        end else if (wdog_fires) begin
            watchdog_reset_cause_flag <= 1'b1;
        end else if (wr_watchdog_control_reg && !pwdata[wdt_pkg::CAUSE_FLAG_BIT]) begin
            watchdog_reset_cause_flag <= 1'b0;
        end
    end

    // A restart in the last grace cycle still beats the reset
    assign wdog_fires = (state == wdt_pkg::WDT_GRACE) && (grace_cnt == GC_W'(1))
                        && !watchdog_restart && watchdog_reset_enable;

    // Final clock of the last machine cycle of the reset pulse
    assign reset_last = (state == wdt_pkg::WDT_RESETTING) && (reset_cnt == RC_W'(1))
                        && (phase == 2'(wdt_pkg::STATES_PER_MACHINE - 1));

    // Post-time-out grace and reset pulse sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state     <= wdt_pkg::WDT_COUNTING;
            grace_cnt <= '0;
            reset_cnt <= '0;
        end else begin
            unique case (state)
                wdt_pkg::WDT_COUNTING: begin
                    if (timeout_pulse) begin
                        state     <= wdt_pkg::WDT_GRACE;
                        grace_cnt <= GC_W'(GRACE_COUNT);
                    end
                end
                wdt_pkg::WDT_GRACE: begin
                    if (watchdog_restart) begin
                        state <= wdt_pkg::WDT_COUNTING;
                    end else if (grace_cnt == GC_W'(1)) begin
                        if (watchdog_reset_enable) begin
                            state     <= wdt_pkg::WDT_RESETTING;
                            reset_cnt <= RC_W'(wdt_pkg::RESET_MACHINE_CYCLES);
                        end else begin
                            state <= wdt_pkg::WDT_COUNTING;
                        end
                    end else begin
                        grace_cnt <= grace_cnt - GC_W'(1);
                    end
                end
                wdt_pkg::WDT_RESETTING: begin
                    if (phase == 2'(wdt_pkg::STATES_PER_MACHINE - 1)) begin
                        if (reset_cnt == RC_W'(1)) begin
                            state <= wdt_pkg::WDT_COUNTING;
                        end
                        reset_cnt <= reset_cnt - RC_W'(1);
                    end
                end
                // Spare encoding of the 2-bit state falls back to counting
                default: begin
                    state <= wdt_pkg::WDT_COUNTING;
                end
            endcase
        end
    end

    // Machine-cycle state counter; realigned as a watchdog reset begins so the pulse spans whole cycles
    always_ff @(posedge clk_sys) begin
        if (reset || wdog_fires) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // Reset output registered from the sequencer
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            system_reset_out <= 1'b0;
        end else begin
            system_reset_out <= (state == wdt_pkg::WDT_RESETTING && !reset_last) || wdog_fires;
        end
    end

    // Interrupt request independent of reset path
    // Registered so the pin cannot glitch while enables are rewritten
    always_ff @(posedge clk_sys) begin
        if (internal_clear) begin
            watchdog_irq <= 1'b0;
        end else begin
            watchdog_irq <= timeout_flag && watchdog_interrupt_enable && global_interrupt_enable;
        end
    end

    // Sticky event status; set wins over clear
    assign evt_set[wdt_pkg::EVT_TIMEOUT_BIT] = timeout_pulse;
    assign evt_set[wdt_pkg::EVT_RESET_BIT]   = wdog_fires;
    generate
        for (genvar i = 0; i < wdt_pkg::EVT_WIDTH; i++) begin : g_evt
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    evt_status[i] <= 1'b0;
                end else if (evt_set[i]) begin
                    evt_status[i] <= 1'b1;
                end else if (wr && paddr == wdt_pkg::OFS_EVT_CLEAR && pwdata[i]) begin
                    evt_status[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // Event enable is unprotected and cleared only by the external reset
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            evt_enable <= '0;
        end else if (wr && paddr == wdt_pkg::OFS_EVT_ENABLE) begin
            evt_enable <= pwdata[wdt_pkg::EVT_WIDTH-1:0];
        end
    end

    // Level output: stays high until the status bit or its enable bit is cleared
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            event_irq <= 1'b0;
        end else begin
            event_irq <= |(evt_status & evt_enable);
        end
    end

    // Registered read data, ready and error in the setup phase for the access phase
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    wdt_pkg::OFS_CLOCK_CONTROL:    prdata <= {24'h00_0000, clock_control_reg};
                    wdt_pkg::OFS_WATCHDOG_CONTROL: prdata <= {24'h00_0000, serial_double, power_on_flag, 2'b00,
                                                              timeout_flag, watchdog_reset_cause_flag,
                                                              watchdog_reset_enable, watchdog_restart};
                    wdt_pkg::OFS_INT_ENABLE:       prdata <= {30'h0000_0000, global_interrupt_enable,
                                                              watchdog_interrupt_enable};
                    wdt_pkg::OFS_EVT_STATUS:       prdata <= {30'h0000_0000, evt_status};
                    wdt_pkg::OFS_EVT_ENABLE:       prdata <= {30'h0000_0000, evt_enable};
                    default:                       prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : wdt_top
`default_nettype wire

// *** include/wdt_pkg.sv ***
// Watchdog timer unit: register map, field positions, reset values and timing counts
package wdt_pkg;

    // APB word offsets (byte addresses)
    localparam logic [7:0] OFS_CLOCK_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_WATCHDOG_CONTROL = 8'h04;
    localparam logic [7:0] OFS_UNLOCK           = 8'h08;
    localparam logic [7:0] OFS_INT_ENABLE       = 8'h0C;
    localparam logic [7:0] OFS_EVT_STATUS       = 8'h10;
    localparam logic [7:0] OFS_EVT_CLEAR        = 8'h14;
    localparam logic [7:0] OFS_EVT_ENABLE       = 8'h18;

    // Clock control register fields
    localparam int SEL_HI_BIT = 7;
    localparam int SEL_LO_BIT = 6;

    // Watchdog control register fields
    localparam int SERIAL_DOUBLE_BIT = 7;
    localparam int POWER_ON_FLAG_BIT = 6;
    localparam int TIMEOUT_FLAG_BIT  = 3;
    localparam int CAUSE_FLAG_BIT    = 2;
    localparam int RESET_ENABLE_BIT  = 1;
    localparam int RESTART_BIT       = 0;

    // Interrupt enable register fields
    localparam int GLOBAL_IE_BIT = 1;
    localparam int WDOG_IE_BIT   = 0;

    // Event status bits
    localparam int EVT_TIMEOUT_BIT = 0;
    localparam int EVT_RESET_BIT   = 1;
    localparam int EVT_WIDTH       = 2;

    // Unlock sequence
    localparam logic [7:0] UNLOCK_FIRST  = 8'hAA;
    localparam logic [7:0] UNLOCK_SECOND = 8'h55;

    // Reset values
    localparam logic [7:0] CLOCK_CONTROL_RESET = 8'h00;
    localparam logic [1:0] INT_ENABLE_RESET    = 2'h0;

    // Timing
    localparam int CLK_PERIOD_NS          = 100;
    localparam int STATES_PER_MACHINE     = 4;
    localparam int UNLOCK_MACHINE_CYCLES  = 3;
    localparam int RESET_MACHINE_CYCLES   = 2;
    localparam int POST_TIMEOUT_CLOCKS    = 512;
    localparam int UNLOCK_CLOCKS          = UNLOCK_MACHINE_CYCLES * STATES_PER_MACHINE;
    localparam int RESET_CLOCKS           = RESET_MACHINE_CYCLES * STATES_PER_MACHINE;

    // Default divider taps per selection code
    localparam int TAP_CODE0 = 17;
    localparam int TAP_CODE1 = 20;
    localparam int TAP_CODE2 = 23;
    localparam int TAP_CODE3 = 26;

    typedef enum logic [1:0] {
        WDT_COUNTING,
        WDT_GRACE,
        WDT_RESETTING
    } wdt_state_t;

endpackage : wdt_pkg

// *** hdl/wdt_unlock.sv ***
// Timed-access unlock sequencer for protected watchdog control bits
`timescale 1ns/1ps
`default_nettype none
module wdt_unlock #(
    parameter int WINDOW_CLOCKS = wdt_pkg::UNLOCK_CLOCKS
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Unlock register write strobe
    input  wire logic       unlock_wr,
    input  wire logic [7:0] unlock_data,
    // Window state
    output logic            window_open
);
    localparam int CW = $clog2(WINDOW_CLOCKS + 1);

    logic          first_seen;
    logic [CW-1:0] remaining;

    // Second byte must be the very next unlock write
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            first_seen <= 1'b0;
        end else if (unlock_wr) begin
            first_seen <= (unlock_data == wdt_pkg::UNLOCK_FIRST);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            remaining <= '0;
        end else if (unlock_wr && first_seen && unlock_data == wdt_pkg::UNLOCK_SECOND) begin
            remaining <= CW'(WINDOW_CLOCKS);
        end else if (remaining != '0) begin
            remaining <= remaining - CW'(1);
        end
    end

    assign window_open = (remaining != '0);
endmodule : wdt_unlock
`default_nettype wire

// *** hdl/wdt_divider.sv ***
// Free-running watchdog divider chain with selectable time-out tap
`timescale 1ns/1ps
`default_nettype none
module wdt_divider #(
    parameter int WIDTH = wdt_pkg::TAP_CODE3,
    parameter int TAP0  = wdt_pkg::TAP_CODE0,
    parameter int TAP1  = wdt_pkg::TAP_CODE1,
    parameter int TAP2  = wdt_pkg::TAP_CODE2,
    parameter int TAP3  = wdt_pkg::TAP_CODE3
) (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       reset,
    // Control
    input  wire logic       restart,
    input  wire logic [1:0] interval_select,
    // Time-out pulse
    output logic            timeout_pulse
);
    logic [WIDTH-1:0] chain;
    logic [WIDTH-1:0] next_chain;
    logic [WIDTH:0]   sum;
    logic             carry;

    assign sum = {1'b0, chain} + {{WIDTH{1'b0}}, 1'b1};
    assign next_chain = sum[WIDTH-1:0];

    // Chain restarts from zero on restart
    always_ff @(posedge clk_sys) begin
        if (reset || restart) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    // Tap rollover: all bits below the selected tap set
    always_comb begin
        carry = 1'b0;
        unique case (interval_select)
            2'd0: carry = &chain[TAP0-1:0];
            2'd1: carry = &chain[TAP1-1:0];
            2'd2: carry = &chain[TAP2-1:0];
            2'd3: carry = &chain[TAP3-1:0];
        endcase
    end

    assign timeout_pulse = carry && !restart;
endmodule : wdt_divider
`default_nettype wire

// *** verif/wdt_top_sva.sv ***
// Port-level assertions for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
module wdt_top_sva (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        reset,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Outputs
    input wire logic        watchdog_irq,
    input wire logic        system_reset_out
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    logic mapped;
    logic rd_done;
    assign mapped  = (paddr[1:0] == 2'b00) && (paddr <= wdt_pkg::OFS_EVT_ENABLE);
    assign rd_done = psel && penable && pready && !pwrite;

    sequence setup_s;
        psel && !penable;
    endsequence
    sequence done_s;
        psel && penable && pready;
    endsequence
    sequence rst_rise_s;
        !system_reset_out ##1 system_reset_out;
    endsequence

    a_zero_wait: assert property (setup_s |=> done_s) else $error("access phase without ready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
    a_err_decode: assert property (done_s |-> pslverr == !mapped) else $error("error response wrong");
    a_err_alone: assert property (pslverr |-> done_s) else $error("error outside access phase");
    a_unlock_reads_zero: assert property (
        rd_done && (paddr == wdt_pkg::OFS_UNLOCK || paddr == wdt_pkg::OFS_EVT_CLEAR) |-> prdata == 32'h0000_0000)
        else $error("write-only register read nonzero");
    a_upper_zero: assert property (rd_done |-> prdata[31:8] == 24'h00_0000) else $error("upper read bits set");
    a_reset_width: assert property (rst_rise_s |-> system_reset_out[*8] ##1 !system_reset_out)
        else $error("system reset width wrong");
    a_reset_gap: assert property ($fell(system_reset_out) |-> !system_reset_out[*8])
        else $error("system reset repeated too soon");
    a_irq_cleared: assert property (system_reset_out[*4] |-> !watchdog_irq)
        else $error("interrupt survives system reset");
    c_reset_seen: cover property (rst_rise_s);
endmodule : wdt_top_sva

bind wdt_top wdt_top_sva i_sva (
    .clk_sys          (clk_sys),
    .reset            (reset),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .watchdog_irq     (watchdog_irq),
    .system_reset_out (system_reset_out)
);
`default_nettype wire

// *** verif/wdt_top_tb.sv ***
// Self-checking testbench for the watchdog timer unit
`timescale 1ns/1ps
`default_nettype none
module wdt_top_tb;
    localparam int         GRACE = 32;
    localparam logic [7:0] CC    = wdt_pkg::OFS_CLOCK_CONTROL;
    localparam logic [7:0] WC    = wdt_pkg::OFS_WATCHDOG_CONTROL;
    localparam logic [7:0] IE    = wdt_pkg::OFS_INT_ENABLE;
    localparam logic [7:0] ES    = wdt_pkg::OFS_EVT_STATUS;
    localparam logic [7:0] EC    = wdt_pkg::OFS_EVT_CLEAR;
    localparam logic [7:0] EE    = wdt_pkg::OFS_EVT_ENABLE;

    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        power_on_reset = 1'b0;
    logic        power_down_reset = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        watchdog_irq;
    logic        event_irq;
    logic        system_reset_out;
    logic [31:0] rd;
    logic        err;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;
    int          n;
    int          el;
    int          e;
    time         t0;

    // Small taps keep every interval short enough to simulate
    wdt_top #(.TAP0(4), .TAP1(5), .TAP2(6), .TAP3(7), .GRACE_COUNT(GRACE)) i_dut (
        .clk_sys(clk_sys), .reset(reset), .power_on_reset(power_on_reset),
        .power_down_reset(power_down_reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdog_irq(watchdog_irq), .event_irq(event_irq), .system_reset_out(system_reset_out));

    always #50 clk_sys = ~clk_sys;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(negedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request held until the edge at which ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic unlock();
        apb(1'b1, wdt_pkg::OFS_UNLOCK, 32'h0000_00AA);
        apb(1'b1, wdt_pkg::OFS_UNLOCK, 32'h0000_0055);
    endtask : unlock

    // Counts cycles until the chosen output reaches lvl, bounded by lim
    task automatic wait_sig(input bit rst, input logic lvl, input int lim);
        n = 0;
        while ((rst ? system_reset_out : event_irq) !== lvl && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
    endtask : wait_sig

    task automatic settle();
        repeat (2) @(negedge clk_sys);
    endtask : settle

    initial begin
        repeat (4) @(posedge clk_sys);
        reset <= 1'b0;
        power_on_reset <= 1'b1;
        @(posedge clk_sys);
        power_on_reset <= 1'b0;
        apb(1'b0, CC, 32'h0); chk(rd, 32'h0);
        apb(1'b0, IE, 32'h0); chk(rd, 32'h0);
        apb(1'b0, WC, 32'h0); chk(rd & 32'h47, 32'h40);
        apb(1'b0, 8'h1C, 32'h0); chk(err, 1'b1);
        apb(1'b0, wdt_pkg::OFS_UNLOCK, 32'h0); chk(rd, 32'h0);
        apb(1'b0, EC, 32'h0); chk(rd, 32'h0);
        apb(1'b1, WC, 32'h82); apb(1'b0, WC, 32'h0); chk(rd & 32'h82, 32'h80);
        unlock(); apb(1'b1, WC, 32'h03); apb(1'b0, WC, 32'h0); chk(rd & 32'h83, 32'h02);
        repeat (12) @(posedge clk_sys);
        apb(1'b1, WC, 32'h0); apb(1'b0, WC, 32'h0); chk(rd & 32'h02, 32'h02);
        unlock(); apb(1'b1, WC, 32'h01);
        apb(1'b1, EE, 32'h1);
        // Every selection code, both paths disabled
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, CC, 32'(c) << 6);
            unlock(); apb(1'b1, WC, 32'h01);
            t0 = $time;
            apb(1'b1, EC, 32'h3);
            settle();
            wait_sig(1'b0, 1'b1, 300);
            el = int'(($time - t0) / 100);
            e = 2 ** (4 + c);
            chk(32'((el >= e - 2 && el <= e + 4) ? e : el), 32'(e));
            apb(1'b0, WC, 32'h0); chk(rd & 32'h08, 32'h08);
            settle(); chk(system_reset_out, 1'b0);
        end
        repeat (40) @(posedge clk_sys);
        apb(1'b0, WC, 32'h0); chk(rd & 32'h08, 32'h08);
        apb(1'b1, IE, 32'h1); settle(); chk(watchdog_irq, 1'b0);
        apb(1'b1, IE, 32'h2); settle(); chk(watchdog_irq, 1'b0);
        apb(1'b1, IE, 32'h3); settle(); chk(watchdog_irq, 1'b1);
        apb(1'b1, EE, 32'h0); settle(); chk(event_irq, 1'b0);
        apb(1'b1, EE, 32'h1); settle(); chk(event_irq, 1'b1);
        apb(1'b1, EC, 32'h1); settle(); chk(event_irq, 1'b0);
        unlock(); apb(1'b1, WC, 32'h01); settle(); chk(watchdog_irq, 1'b0);
        // Reset path after grace, then restart cancels a pending countdown
        apb(1'b1, CC, 32'h0);
        unlock(); apb(1'b1, WC, 32'h03);
        t0 = $time;
        wait_sig(1'b1, 1'b1, 400);
        el = int'(($time - t0) / 100);
        e = 16 + GRACE;
        chk(32'((el >= e - 2 && el <= e + 4) ? e : el), 32'(e));
        wait_sig(1'b1, 1'b0, 20); chk(32'(n), 32'(wdt_pkg::RESET_CLOCKS));
        chk(watchdog_irq, 1'b0);
        apb(1'b0, WC, 32'h0); chk(rd & 32'h06, 32'h06);
        apb(1'b0, ES, 32'h0); chk(rd & 32'h2, 32'h2);
        apb(1'b1, EC, 32'h3); settle();
        wait_sig(1'b0, 1'b1, 100);
        unlock(); apb(1'b1, WC, 32'h07);
        wait_sig(1'b1, 1'b1, 30); chk(32'(n), 32'd30);
        unlock(); apb(1'b1, WC, 32'h05);
        // External reset keeps the cause flag, power-down clears it
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        apb(1'b0, WC, 32'h0); chk(rd & 32'h04, 32'h04);
        power_down_reset <= 1'b1;
        @(posedge clk_sys);
        power_down_reset <= 1'b0;
        apb(1'b0, WC, 32'h0); chk(rd & 32'h04, 32'h0);
        tally_and_finish();
    end
endmodule : wdt_top_tb
`default_nettype wire
